/* File: logic/port_pin_mode_defines.svh */
`ifndef PORT_PIN_MODE_DEFINES_SVH
`define PORT_PIN_MODE_DEFINES_SVH

// Register byte offsets
`define OFS_PORT_DATA 8'h00
`define OFS_OUTPUT_MODE 8'h04
`define OFS_INPUT_MODE 8'h08
`define OFS_CROSSBAR_ONE 8'h0C
`define OFS_CROSSBAR_TWO 8'h10
`define OFS_PIN_STATE 8'h14

// Reset values
`define RST_PORT_DATA 32'hFFFFFFFF
`define RST_OUTPUT_MODE 32'h00000000
`define RST_INPUT_MODE 16'hFFFF
`define RST_CROSSBAR_ONE 3'h0
`define RST_CROSSBAR_TWO 8'h00

// Field positions
`define BIT_PULLUP_DISABLE 7
`define BIT_XBAR_SMBUS 0
`define BIT_XBAR_UART_A 1
`define BIT_XBAR_UART_B 2

// Port layout: port 1 holds pins 15..8, port 2 pins 23..16
`define PIN_COUNT 32
`define PORT1_LSB 8
`define PORT2_LSB 16
`define FUNC_COUNT 6

`endif

/* File: logic/port_pin_mode_pkg.sv */
`default_nettype none
package port_pin_mode_pkg;

    // Crossbar functions in allocation priority order
    typedef enum logic [2:0] {
        func_none,
        func_sda,
        func_scl,
        func_uart_a_tx,
        func_uart_a_rx,
        func_uart_b_tx,
        func_uart_b_rx
    } func_type;

    typedef func_type [31:0] pin_sel_type;

    typedef struct packed {
        pin_sel_type sel;
    } xbar_state_type;

    typedef struct packed {
        logic [31:0] latch;
        logic [31:0] out_mode;
        logic [15:0] in_mode;
        logic [2:0] xbar_en;
        logic [7:0] ctrl_two;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] pin_out;
        logic [31:0] pin_oe;
        logic [31:0] pullup_en;
        logic sda_in;
        logic scl_in;
        logic uart_a_rx_in;
        logic uart_b_rx_in;
        logic [7:0] aux_mux_in;
        logic [7:0] comp_in;
    } top_state_type;

endpackage : port_pin_mode_pkg
`default_nettype wire

/* File: logic/xbar_link_if.sv */
`default_nettype none
interface xbar_link_if;
    logic [31:0] analog_mask;
    logic [2:0] func_en;
    port_pin_mode_pkg::pin_sel_type sel;

    modport xbar (
        input analog_mask,
        input func_en,
        output sel
    );

    modport drv (
        input analog_mask,
        input sel
    );
endinterface : xbar_link_if
`default_nettype wire

/* File: logic/pin_crossbar.sv */
`include "port_pin_mode_defines.svh"
`default_nettype none
module pin_crossbar (
    input wire logic clk_sys,
    input wire logic rstn,
    xbar_link_if.xbar link
);
    port_pin_mode_pkg::xbar_state_type state_ff;
    port_pin_mode_pkg::xbar_state_type nxt_state;
    port_pin_mode_pkg::func_type order [`FUNC_COUNT];
    logic [`FUNC_COUNT-1:0] want;

    always_comb begin
        int next;
        next = 0;
        order[0] = port_pin_mode_pkg::func_sda;
        order[1] = port_pin_mode_pkg::func_scl;
        order[2] = port_pin_mode_pkg::func_uart_a_tx;
        order[3] = port_pin_mode_pkg::func_uart_a_rx;
        order[4] = port_pin_mode_pkg::func_uart_b_tx;
        order[5] = port_pin_mode_pkg::func_uart_b_rx;
        want = {{2{link.func_en[`BIT_XBAR_UART_B]}},
                {2{link.func_en[`BIT_XBAR_UART_A]}},
                {2{link.func_en[`BIT_XBAR_SMBUS]}}};
        nxt_state = '0;
        // Skip disabled functions first, then walk the pins
        for (int p = 0; p < `PIN_COUNT; p++) begin
            while (next < `FUNC_COUNT && !want[next]) begin
                next = next + 1;
            end
            // Analog pins are passed over; the same function goes to the next pin
            if (!link.analog_mask[p] && next < `FUNC_COUNT) begin
                nxt_state.sel[p] = order[next];
                next = next + 1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign link.sel = state_ff.sel;
endmodule : pin_crossbar
`default_nettype wire

/* File: logic/pin_driver.sv */
`include "port_pin_mode_defines.svh"
`default_nettype none
module pin_driver (
    xbar_link_if.drv link,
    input wire logic [31:0] latch,
    input wire logic [31:0] out_mode,
    input wire logic pullup_off,
    input wire logic [31:0] pin_in,
    input wire logic sda_drive,
    input wire logic scl_drive,
    input wire logic uart_a_tx,
    input wire logic uart_b_tx,
    input wire logic uart_a_rx_drive,
    input wire logic uart_b_rx_drive,
    input wire logic uart_a_mode0,
    input wire logic uart_b_mode0,
    output logic [31:0] nxt_pin_out,
    output logic [31:0] nxt_pin_oe,
    output logic [31:0] nxt_pullup_en,
    output logic [31:0] digital_in,
    output logic nxt_sda_in,
    output logic nxt_scl_in,
    output logic nxt_uart_a_rx_in,
    output logic nxt_uart_b_rx_in
);
    always_comb begin
        logic value;
        logic od;
        logic drive;
        value = 1'b0;
        od = 1'b0;
        drive = 1'b0;
        nxt_sda_in = 1'b1;
        nxt_scl_in = 1'b1;
        nxt_uart_a_rx_in = 1'b1;
        nxt_uart_b_rx_in = 1'b1;
        digital_in = pin_in & ~link.analog_mask;
        for (int p = 0; p < `PIN_COUNT; p++) begin
            value = latch[p];
            od = !out_mode[p];
            drive = 1'b1;
            case (link.sel[p])
                port_pin_mode_pkg::func_none: begin
                    value = latch[p];
                end
                port_pin_mode_pkg::func_sda: begin
                    value = sda_drive;
                    od = 1'b1;
                    nxt_sda_in = digital_in[p];
                end
                port_pin_mode_pkg::func_scl: begin
                    value = scl_drive;
                    od = 1'b1;
                    nxt_scl_in = digital_in[p];
                end
                port_pin_mode_pkg::func_uart_a_tx: begin
                    value = uart_a_tx;
                end
                port_pin_mode_pkg::func_uart_a_rx: begin
                    value = uart_a_rx_drive;
                    od = 1'b1;
                    drive = uart_a_mode0;
                    nxt_uart_a_rx_in = digital_in[p];
                end
                port_pin_mode_pkg::func_uart_b_tx: begin
                    value = uart_b_tx;
                end
                port_pin_mode_pkg::func_uart_b_rx: begin
                    value = uart_b_rx_drive;
                    od = 1'b1;
                    drive = uart_b_mode0;
                    nxt_uart_b_rx_in = digital_in[p];
                end
                default: begin
                    value = latch[p];
                end
            endcase
            // Open-drain only ever pulls low; a 1 leaves the pin floating
            nxt_pin_out[p] = od ? 1'b0 : value;
            nxt_pin_oe[p] = drive && (!od || !value);
            // Analog drops the pull-up, drivers stay as configured
            nxt_pullup_en[p] = !pullup_off
                && !link.analog_mask[p]
                && !(nxt_pin_oe[p] && !nxt_pin_out[p]);
        end
    end
endmodule : pin_driver
`default_nettype wire

/* File: logic/port_pin_mode_config.sv */
// Summary of operation
// - Output mode bit picks push-pull or open-drain, crossbar or not.
// - SDA, SCL and mode-0 UART receive pins are always open-drain.
// - UART receive pins have drivers disabled unless that UART is in mode 0.
// - Weak pull-ups are on after reset unless globally or mode disabled.
// - Writing 1 to bit 7 of crossbar control two disables all pull-ups.
// - A pin driving 0 has its pull-up switched off.
// - Input mode bit 0 selects analog; reset leaves all pins digital.
// - Analog pins have no digital input path and read back as 0.
// - Analog mode also disables the pin pull-up.
// - Crossbar skips analog pins and assigns the next eligible pin.
// - Port 1 pins feed the converter mux, port 2 pins the comparators.
`include "port_pin_mode_defines.svh"
`default_nettype none
module port_pin_mode_config (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    output logic [31:0] pullup_en,
    input wire logic sda_drive,
    input wire logic scl_drive,
    input wire logic uart_a_tx,
    input wire logic uart_b_tx,
    input wire logic uart_a_rx_drive,
    input wire logic uart_b_rx_drive,
    input wire logic uart_a_mode0,
    input wire logic uart_b_mode0,
    output logic sda_in,
    output logic scl_in,
    output logic uart_a_rx_in,
    output logic uart_b_rx_in,
    output logic [7:0] aux_mux_in,
    output logic [7:0] comp_in
);
    port_pin_mode_pkg::top_state_type state_ff;
    port_pin_mode_pkg::top_state_type nxt_state;

    logic [31:0] analog_mask;
    logic [31:0] digital_in;
    logic [31:0] drv_out;
    logic [31:0] drv_oe;
    logic [31:0] drv_pullup;
    logic drv_sda;
    logic drv_scl;
    logic drv_rx_a;
    logic drv_rx_b;
    logic access;
    logic do_write;
    logic mapped;

    xbar_link_if link ();

    // Byte-lane merge shared by every writable register
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic logic is_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            `OFS_PORT_DATA: hit = 1'b1;
            `OFS_OUTPUT_MODE: hit = 1'b1;
            `OFS_INPUT_MODE: hit = 1'b1;
            `OFS_CROSSBAR_ONE: hit = 1'b1;
            `OFS_CROSSBAR_TWO: hit = 1'b1;
            `OFS_PIN_STATE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : is_mapped

    // Only ports 1 and 2 carry an input mode field
    always_comb begin
        analog_mask = '0;
        analog_mask[`PORT1_LSB +: 8] = ~state_ff.in_mode[7:0];
        analog_mask[`PORT2_LSB +: 8] = ~state_ff.in_mode[15:8];
    end

    assign link.analog_mask = analog_mask;
    assign link.func_en = state_ff.xbar_en;

    pin_crossbar u_crossbar (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .link(link.xbar)
    );

    pin_driver u_driver (
        .link(link.drv),
        .latch(state_ff.latch),
        .out_mode(state_ff.out_mode),
        .pullup_off(state_ff.ctrl_two[`BIT_PULLUP_DISABLE]),
        .pin_in(pin_in),
        .sda_drive(sda_drive),
        .scl_drive(scl_drive),
        .uart_a_tx(uart_a_tx),
        .uart_b_tx(uart_b_tx),
        .uart_a_rx_drive(uart_a_rx_drive),
        .uart_b_rx_drive(uart_b_rx_drive),
        .uart_a_mode0(uart_a_mode0),
        .uart_b_mode0(uart_b_mode0),
        .nxt_pin_out(drv_out),
        .nxt_pin_oe(drv_oe),
        .nxt_pullup_en(drv_pullup),
        .digital_in(digital_in),
        .nxt_sda_in(drv_sda),
        .nxt_scl_in(drv_scl),
        .nxt_uart_a_rx_in(drv_rx_a),
        .nxt_uart_b_rx_in(drv_rx_b)
    );

    // Access phase holds two cycles: pready is a flop, so it rises one late
    assign access = psel && penable && !state_ff.pready;
    assign mapped = is_mapped(paddr);
    assign do_write = psel && penable && state_ff.pready && pwrite && mapped;

    always_comb begin
        logic [31:0] merged;
        merged = 32'h00000000;
        nxt_state = state_ff;
        nxt_state.pready = access;
        nxt_state.pslverr = access && !mapped;
        if (access && !pwrite) begin
            case (paddr)
                `OFS_PORT_DATA: nxt_state.prdata = digital_in;
                `OFS_OUTPUT_MODE: nxt_state.prdata = state_ff.out_mode;
                `OFS_INPUT_MODE: nxt_state.prdata = {16'h0000, state_ff.in_mode};
                `OFS_CROSSBAR_ONE: nxt_state.prdata = {29'h0, state_ff.xbar_en};
                `OFS_CROSSBAR_TWO: nxt_state.prdata = {24'h000000, state_ff.ctrl_two};
                `OFS_PIN_STATE: nxt_state.prdata = state_ff.pullup_en;
                default: nxt_state.prdata = 32'h00000000;
            endcase
        end else if (access) begin
            nxt_state.prdata = 32'h00000000;
        end
        // Writes land at the edge that completes the transfer
        if (do_write) begin
            case (paddr)
                `OFS_PORT_DATA: begin
                    nxt_state.latch = merge(state_ff.latch, pwdata, pstrb);
                end
                `OFS_OUTPUT_MODE: begin
                    nxt_state.out_mode = merge(state_ff.out_mode, pwdata, pstrb);
                end
                `OFS_INPUT_MODE: begin
                    merged = merge({16'h0000, state_ff.in_mode}, pwdata, pstrb);
                    nxt_state.in_mode = merged[15:0];
                end
                `OFS_CROSSBAR_ONE: begin
                    merged = merge({29'h0, state_ff.xbar_en}, pwdata, pstrb);
                    nxt_state.xbar_en = merged[2:0];
                end
                `OFS_CROSSBAR_TWO: begin
                    merged = merge({24'h000000, state_ff.ctrl_two}, pwdata, pstrb);
                    nxt_state.ctrl_two = merged[7:0];
                end
                default: begin
                    nxt_state.ctrl_two = state_ff.ctrl_two;
                end
            endcase
        end
        // Pin side follows the driver one clock later
        nxt_state.pin_out = drv_out;
        nxt_state.pin_oe = drv_oe;
        nxt_state.pullup_en = drv_pullup;
        nxt_state.sda_in = drv_sda;
        nxt_state.scl_in = drv_scl;
        nxt_state.uart_a_rx_in = drv_rx_a;
        nxt_state.uart_b_rx_in = drv_rx_b;
        // Analog candidates are passed whatever the mode bit says
        nxt_state.aux_mux_in = pin_in[`PORT1_LSB +: 8];
        nxt_state.comp_in = pin_in[`PORT2_LSB +: 8];
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff.latch <= `RST_PORT_DATA;
            state_ff.out_mode <= `RST_OUTPUT_MODE;
            state_ff.in_mode <= `RST_INPUT_MODE;
            state_ff.xbar_en <= `RST_CROSSBAR_ONE;
            state_ff.ctrl_two <= `RST_CROSSBAR_TWO;
            state_ff.pready <= 1'b0;
            state_ff.pslverr <= 1'b0;
            state_ff.prdata <= 32'h00000000;
            state_ff.pin_out <= 32'h00000000;
            state_ff.pin_oe <= 32'h00000000;
            state_ff.pullup_en <= 32'hFFFFFFFF;
            state_ff.sda_in <= 1'b1;
            state_ff.scl_in <= 1'b1;
            state_ff.uart_a_rx_in <= 1'b1;
            state_ff.uart_b_rx_in <= 1'b1;
            state_ff.aux_mux_in <= 8'h00;
            state_ff.comp_in <= 8'h00;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = state_ff.prdata;
    assign pready = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign pin_out = state_ff.pin_out;
    assign pin_oe = state_ff.pin_oe;
    assign pullup_en = state_ff.pullup_en;
    assign sda_in = state_ff.sda_in;
    assign scl_in = state_ff.scl_in;
    assign uart_a_rx_in = state_ff.uart_a_rx_in;
    assign uart_b_rx_in = state_ff.uart_b_rx_in;
    assign aux_mux_in = state_ff.aux_mux_in;
    assign comp_in = state_ff.comp_in;
endmodule : port_pin_mode_config
`default_nettype wire

/* File: tb/pin_mode_asserts.sv */
`default_nettype none
module pin_mode_asserts (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pullup_en,
    input wire logic [7:0] aux_mux_in,
    input wire logic [7:0] comp_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Low only on the first edge after each reset release
    logic up_ff;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            up_ff <= 1'b0;
        end else begin
            up_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wdone_s;
        psel && penable && pwrite && pready && pstrb[0];
    endsequence
    sequence pud_wr_s;
        wdone_s ##0 (paddr == 8'h10 && pwdata[7]);
    endsequence
    sequence analog_wr_s;
        wdone_s ##0 (paddr == 8'h08 && !pwdata[4]);
    endsequence

    chk_ready_two_cycles: assert property (setup_s |=> !pready ##1 pready)
        else $error("pready not two cycles after setup");
    chk_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_unmapped: assert property (psel && penable && pready |->
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
        else $error("pslverr does not match address decode");
    chk_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response without zero data");
    chk_reset_pullups: assert property (!up_ff |-> pullup_en == 32'hFFFFFFFF && pin_oe == 32'h0)
        else $error("pins not in reset state after release");
    chk_global_pullup_off: assert property (pud_wr_s |-> ##[1:2] pullup_en == 32'h0)
        else $error("global pull-up disable ignored");
    chk_no_fight: assert property ((pin_oe & ~pin_out & pullup_en) == 32'h0)
        else $error("pull-up on while pin drives low");
    chk_analog_pullup_off: assert property (analog_wr_s |-> ##[1:2] !pullup_en[12])
        else $error("analog pin keeps its pull-up");
    chk_analog_routes: assert property (up_ff |-> {comp_in, aux_mux_in} == $past(pin_in[23:8]))
        else $error("converter or comparator input not routed");
endmodule : pin_mode_asserts

bind port_pin_mode_config pin_mode_asserts chk_i (.clk_sys, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
    .pullup_en, .aux_mux_in, .comp_in);
`default_nettype wire

/* File: tb/board_pins.sv */
`default_nettype none
module board_pins (
    input wire logic clk_sys,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] pullup_en,
    input wire logic [31:0] ext_en,
    input wire logic [31:0] ext_val,
    output logic [31:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven pins without pull-up wander, so a stale level is never trusted
    logic [31:0] float_ff = 32'h5A5AA5A5;
    always @(posedge clk_sys) float_ff <= ~float_ff;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_en | float_ff));
endmodule : board_pins
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, aux_mux_in, comp_in;
    logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pullup_en, ext_en, ext_val, rd;
    logic [3:0] pstrb;
    logic sda_drive, scl_drive, uart_a_tx, uart_b_tx, uart_a_rx_drive, uart_b_rx_drive;
    logic uart_a_mode0, uart_b_mode0, sda_in, scl_in, uart_a_rx_in, uart_b_rx_in;
    int miscompares = 0;
    int n_checks = 0;

    port_pin_mode_config dut (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pullup_en,
        .sda_drive, .scl_drive, .uart_a_tx, .uart_b_tx, .uart_a_rx_drive, .uart_b_rx_drive,
        .uart_a_mode0, .uart_b_mode0, .sda_in, .scl_in, .uart_a_rx_in, .uart_b_rx_in,
        .aux_mux_in, .comp_in);
    board_pins board (.clk_sys, .pin_out, .pin_oe, .pullup_en, .ext_en, .ext_val, .pin_in);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task end_sim;
        $display("Checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s: got %h, want %h", $time, what, got, exp);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        check(pready, 32'h1, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr

    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hF);
        check(rd, exp, "register read");
    endtask : rchk

    task settle;
        repeat (4) @(posedge clk_sys);
    endtask : settle

    task t_reset;
        settle;
        check(pullup_en, 32'hFFFFFFFF, "pull-ups after reset");
        check(pin_oe, 32'h0, "drivers after reset");
        rchk(8'h04, 32'h0);
        rchk(8'h08, 32'h0000FFFF);
        rchk(8'h0C, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h14, 32'hFFFFFFFF);
        rchk(8'h18, 32'h0);
        check(err, 32'h1, "unmapped not refused");
        $display("t_reset done");
    endtask : t_reset

    task t_drive;
        wr(8'h04, 32'h0000000F);
        wr(8'h00, 32'hFFFFFF33);
        ext_en <= 32'h00000030;
        ext_val <= 32'h00000010;
        settle;
        check(pin_oe[7:0], 32'hCF, "driver enables");
        check(pin_out[7:0], 32'h03, "driven values");
        check(pullup_en[7:0], 32'h33, "pull-ups on low pins");
        apb(1'b0, 8'h00, 32'h0, 4'hF);
        check(rd[7:0], 32'h13, "digital input read");
        wr(8'h04, 32'h0);
        wr(8'h00, 32'hFFFFFFFF);
        ext_en <= 32'h0;
        $display("t_drive done");
    endtask : t_drive

    task t_pullup;
        wr(8'h10, 32'h00000080);
        settle;
        check(pullup_en, 32'h0, "global disable");
        rchk(8'h10, 32'h00000080);
        rchk(8'h14, 32'h0);
        wr(8'h10, 32'h0);
        settle;
        check(pullup_en, 32'hFFFFFFFF, "pull-ups back");
        $display("t_pullup done");
    endtask : t_pullup

    task t_analog;
        ext_en <= 32'h00FFFF00;
        ext_val <= 32'h00A5C300;
        // Latch stays 1 and mode open-drain on the analog pins
        wr(8'h08, 32'h00000F0F);
        settle;
        check(aux_mux_in, 32'hC3, "converter inputs");
        check(comp_in, 32'hA5, "comparator inputs");
        check(pullup_en[23:8], 32'h0F0F, "analog pull-ups");
        apb(1'b0, 8'h00, 32'h0, 4'hF);
        check(rd[23:8], 32'h0503, "analog read zero");
        rchk(8'h08, 32'h00000F0F);
        wr(8'h08, 32'h0000FFFF);
        ext_en <= 32'h0;
        $display("t_analog done");
    endtask : t_analog

    task t_xbar;
        // Previous test released ext_en in this time step
        @(posedge clk_sys);
        {sda_drive, scl_drive, uart_a_tx, uart_b_tx} <= 4'hA;
        {uart_a_mode0, uart_b_mode0, uart_b_rx_drive} <= 3'h2;
        ext_en <= 32'h00000009;
        ext_val <= 32'h0;
        wr(8'h04, 32'hFFFFFFFF);
        wr(8'h0C, 32'h00000007);
        settle;
        check(pin_oe[7:0], 32'hF6, "crossbar enables");
        check(pin_out[7:0], 32'hC4, "crossbar values");
        check({sda_in, scl_in, uart_a_rx_in, uart_b_rx_in}, 32'h0, "peripheral inputs");
        {sda_drive, uart_b_mode0} <= 2'h0;
        settle;
        check(pin_oe[7:0], 32'hD7, "receive pin released");
        wr(8'h0C, 32'h0);
        wr(8'h04, 32'h0);
        ext_en <= 32'h0;
        $display("t_xbar done");
    endtask : t_xbar

    task t_reset_mid;
        apb(1'b1, 8'h04, 32'hFFFFFFFF, 4'h1);
        rchk(8'h04, 32'h000000FF);
        wr(8'h10, 32'h00000080);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        settle;
        check(pullup_en, 32'hFFFFFFFF, "pull-ups after reset");
        rchk(8'h04, 32'h0);
        rchk(8'h10, 32'h0);
        $display("t_reset_mid done");
    endtask : t_reset_mid

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        $display("ERROR %0t watchdog expired", $time);
        end_sim;
    end

    initial begin
        {rstn, psel, penable, pwrite, sda_drive, scl_drive, uart_a_tx, uart_b_tx} = 8'h0;
        {uart_a_rx_drive, uart_b_rx_drive, uart_a_mode0, uart_b_mode0} = 4'h0;
        {paddr, pwdata, pstrb, ext_en, ext_val} = 108'h0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset;
        t_drive;
        t_pullup;
        t_analog;
        t_xbar;
        t_reset_mid;
        end_sim;
    end
endmodule : tb
`default_nettype wire
